//--- core/cce_map.svh
`ifndef CCE_MAP_SVH
`define CCE_MAP_SVH
// Register byte offsets.
`define CCE_OFF_CFG5      8'h14
`define CCE_OFF_CFG6      8'h18
`define CCE_OFF_CFG7      8'h1C
`define CCE_OFF_CTRL      8'h20
`define CCE_OFF_MSTAT     8'h24
`define CCE_OFF_SSTAT     8'h28
// Configuration register 5 fields.
`define CCE_CFG5_SRC_BIT  7
`define CCE_CFG5_STAT_BIT 6
`define CCE_CFG5_RESET    8'hFF
// Control register fields.
`define CCE_CTRL_CHKEN    0
`define CCE_CTRL_SFBEN    1
`define CCE_CTRL_ASYNC    2
`define CCE_CTRL_RESET    8'h00
// Timing in ns and derived cycle counts at 100 MHz.
`define CCE_CLK_NS        10
`define CCE_T_START_NS    50
`define CCE_T_WIDTH_NS    50
`define CCE_T_EXT_NS      150
`define CCE_T_REL_NS      40
`define CCE_START_CYC     (`CCE_T_START_NS / `CCE_CLK_NS)
`define CCE_WIDTH_CYC     ((`CCE_T_WIDTH_NS + `CCE_CLK_NS - 1) / `CCE_CLK_NS)
`define CCE_EXT_CYC       (`CCE_T_EXT_NS / `CCE_CLK_NS)
`define CCE_REL_CYC       (`CCE_T_REL_NS / `CCE_CLK_NS)
`endif

//--- core/cce_pkg.sv
package cce_pkg;
    typedef enum logic [1:0]
    {
        CCE_IDLE  = 2'b00,
        CCE_WAIT  = 2'b01,
        CCE_PULSE = 2'b11,
        CCE_HOLD  = 2'b10
    } cce_state_e;
    typedef struct packed
    {
        logic cmdActive;
        logic parityEnable;
        logic cardReady;
        logic streaming;
        logic writeCycle;
        logic lastStrobe;
        logic asyncExtended;
    } cce_chan_s;
    typedef struct packed
    {
        logic writeParityErr;
        logic addrParityErr;
        logic nonParityErr;
        logic slaveErr;
        logic asyncErr;
        logic [7:0] cause;
    } cce_event_s;
endpackage : cce_pkg

//--- core/cce_check_unit.sv
`timescale 1ns/1ps
`include "cce_map.svh"
// Behaviour
// RQ1 - Source clears register5 bit7, except address parity
// RQ2 - Cause in registers 6/7, clear bit6
// RQ3 - Writing 1 to bit7 clears check
// RQ4 - Unsupported check reads bit7 as one
// RQ5 - Synchronous check is a pulse
// RQ6 - Enable field gates non-parity slave reports
// RQ7 - Pulse within 50ns, width at least 50ns
// RQ8 - Write parity timed from later strobe
// RQ9 - Slave stretches cycle dropping channel ready
// RQ10 - Extended: 150ns from command, 50ns ready
// RQ11 - Streaming read check within 50ns strobe
// RQ12 - Streaming write check gated by parity enable
// RQ13 - Asynchronous check latched until bit7 written
// RQ14 - Asynchronous only for non-parity, slave errors
// RQ15 - System master ignores check during status read
// RQ16 - Master status: read parity, check, feedback
// RQ17 - Slave status: write parity, internal error
// RQ18 - Master monitors check, posts interrupt
// RQ19 - DMA records status, drives terminal count
// RQ20 - Capture feedback state; absence report enabled
// RQ21 - Address parity master receives feedback return
// RQ22 - Missing feedback raises select feedback exception
// RQ23 - Clears happen synchronously on bit7 write
module cce_check_unit #(
    parameter bit CHK_SUPPORTED = 1'b1
) (
    // System.
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // Wishbone slave.
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Channel, slave side.
    input  wire cce_pkg::cce_chan_s chan,
    input  wire cce_pkg::cce_event_s evt,
    output logic                   channel_check_line_n_o,
    output logic                   channel_check_line_n_oe,
    output logic                   card_channel_ready_o,
    // Channel, master side.
    input  wire logic              channel_check_n,
    input  wire logic              select_feedback_return_n,
    input  wire logic              masterOwns,
    input  wire logic              masterXferEnd,
    input  wire logic              readParityErr,
    input  wire logic              dmaSlaveSelected,
    output logic                   terminal_count_n,
    output logic                   masterIrq,
    output logic                   suspendXfer
);
    // ************************************************************
    // Bus decode.
    // ************************************************************
    wire logic busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic busWr    = busReq & wb_we_i & wb_sel_i[0];
    wire logic hitCfg5  = (wb_adr_i == `CCE_OFF_CFG5);
    wire logic hitCfg6  = (wb_adr_i == `CCE_OFF_CFG6);
    wire logic hitCfg7  = (wb_adr_i == `CCE_OFF_CFG7);
    wire logic hitCtrl  = (wb_adr_i == `CCE_OFF_CTRL);
    wire logic hitMstat = (wb_adr_i == `CCE_OFF_MSTAT);
    wire logic hitSstat = (wb_adr_i == `CCE_OFF_SSTAT);
    wire logic clrSrc   = busWr & hitCfg5 & wb_dat_i[`CCE_CFG5_SRC_BIT];
    wire logic ctlWr    = busWr & hitCtrl;
    wire logic mstWr    = busWr & hitMstat;
    wire logic sslWr    = busWr & hitSstat;

    logic [7:0] cfg5_reg;
    logic [7:0] cfg6_reg;
    logic [7:0] cfg7_reg;
    logic [7:0] ctrl_reg;
    logic [4:0] mstat_reg;
    logic [1:0] sstat_reg;
    logic       async_reg;
    wire logic chkEn  = ctrl_reg[`CCE_CTRL_CHKEN];
    wire logic sfbEn  = ctrl_reg[`CCE_CTRL_SFBEN];
    wire logic stsRd  = ctrl_reg[`CCE_CTRL_ASYNC];

    // ************************************************************
    // Synchronous and asynchronous check trigger.
    // ************************************************************
    wire logic parityTrig = evt.writeParityErr & chan.cmdActive & chan.parityEnable; // RQ8
    wire logic otherTrig  = chan.cmdActive & (evt.addrParityErr
                          | (chkEn & (evt.nonParityErr | evt.slaveErr))); // RQ6
    wire logic syncTrig   = CHK_SUPPORTED & (parityTrig | otherTrig);
    wire logic asyncTrig  = CHK_SUPPORTED & chkEn & evt.asyncErr & ~chan.cmdActive; // RQ14
    wire logic setSrc     = (syncTrig & ~evt.addrParityErr) | asyncTrig; // RQ1

    cce_pkg::cce_state_e state_reg, state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic       strWr_reg;
    wire logic extended   = chan.asyncExtended | chan.streaming;
    wire logic readyOk    = chan.cardReady;
    wire logic widthDone  = (cnt_reg >= 5'(`CCE_WIDTH_CYC - 1));
    wire logic gateOff    = strWr_reg ? ~chan.parityEnable : ~chan.cmdActive; // RQ12
    wire logic rdGate     = ~chan.streaming | chan.writeCycle | chan.lastStrobe; // RQ11

    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg + 5'h01;
        case (state_reg)
            cce_pkg::CCE_IDLE:
            begin
                cnt_next = 5'h00;
                if (syncTrig)
                    state_next = extended ? cce_pkg::CCE_WAIT : cce_pkg::CCE_PULSE; // RQ9
            end
            cce_pkg::CCE_WAIT:
            begin
                if (readyOk & rdGate)
                begin
                    state_next = cce_pkg::CCE_PULSE; // RQ10
                    cnt_next   = 5'h00;
                end
            end
            cce_pkg::CCE_PULSE:
            begin
                if (widthDone)
                    state_next = cce_pkg::CCE_HOLD; // RQ7
            end
            cce_pkg::CCE_HOLD:
            begin
                if (gateOff)
                    state_next = cce_pkg::CCE_IDLE; // RQ5
            end
            default:
                state_next = cce_pkg::CCE_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= cce_pkg::CCE_IDLE;
            cnt_reg   <= 5'h00;
            strWr_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            if (state_reg == cce_pkg::CCE_IDLE)
                strWr_reg <= chan.streaming & chan.writeCycle;
        end
    end

    wire logic pulseOn = (state_reg == cce_pkg::CCE_PULSE) | (state_reg == cce_pkg::CCE_HOLD);
    assign channel_check_line_n_o  = 1'b0;
    assign channel_check_line_n_oe = pulseOn | async_reg; // RQ13
    assign card_channel_ready_o    = (state_reg != cce_pkg::CCE_WAIT) | readyOk; // RQ9

    // ************************************************************
    // Configuration and status registers.
    // ************************************************************
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfg5_reg  <= `CCE_CFG5_RESET;
            cfg6_reg  <= 8'h00;
            cfg7_reg  <= 8'h00;
            ctrl_reg  <= `CCE_CTRL_RESET;
            async_reg <= 1'b0;
            sstat_reg <= 2'b00;
        end
        else
        begin
            if (ctlWr)
                ctrl_reg <= wb_dat_i[7:0];
            if (setSrc)
            begin
                cfg5_reg[`CCE_CFG5_SRC_BIT]  <= 1'b0; // RQ1
                cfg5_reg[`CCE_CFG5_STAT_BIT] <= 1'b0; // RQ2
                cfg6_reg <= evt.cause; // RQ2
                cfg7_reg <= {3'h0, evt.asyncErr, evt.slaveErr, evt.nonParityErr,
                             evt.addrParityErr, evt.writeParityErr};
            end
            else if (clrSrc)
            begin
                cfg5_reg[`CCE_CFG5_SRC_BIT]  <= 1'b1; // RQ3 RQ23
                cfg5_reg[`CCE_CFG5_STAT_BIT] <= 1'b1;
            end
            if (asyncTrig)
                async_reg <= 1'b1; // RQ13
            else if (clrSrc)
                async_reg <= 1'b0; // RQ23
            sstat_reg <= sslWr ? (sstat_reg & ~wb_dat_i[1:0]) | {evt.slaveErr, evt.writeParityErr}
                               : sstat_reg | {evt.slaveErr, evt.writeParityErr}; // RQ17
        end
    end

    wire logic [7:0] cfg5View = CHK_SUPPORTED ? cfg5_reg : (cfg5_reg | 8'h80); // RQ4

    // ************************************************************
    // Master side exception capture.
    // ************************************************************
    wire logic chkSeen  = masterOwns & ~channel_check_n & ~stsRd; // RQ18 RQ15
    wire logic sfbMiss  = masterOwns & masterXferEnd & select_feedback_return_n; // RQ22 RQ21
    wire logic sfbEvt   = sfbMiss & sfbEn; // RQ20
    wire logic anyMEvt  = chkSeen | sfbEvt | (masterOwns & readParityErr);
    logic tcPend_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            mstat_reg  <= 5'h00;
            tcPend_reg <= 1'b0;
        end
        else
        begin
            if (anyMEvt)
            begin
                mstat_reg[0] <= mstat_reg[0] | (masterOwns & readParityErr); // RQ16
                mstat_reg[1] <= mstat_reg[1] | chkSeen; // RQ16
                mstat_reg[2] <= ~select_feedback_return_n; // RQ20
                mstat_reg[3] <= mstat_reg[3] | sfbEvt; // RQ22
                mstat_reg[4] <= 1'b1; // RQ18
            end
            else if (mstWr)
                mstat_reg <= mstat_reg & ~wb_dat_i[4:0];
            if (anyMEvt & ~dmaSlaveSelected)
                tcPend_reg <= 1'b1; // RQ19
            else if (dmaSlaveSelected)
                tcPend_reg <= 1'b0;
        end
    end

    assign terminal_count_n = ~(dmaSlaveSelected & (anyMEvt | tcPend_reg)); // RQ19
    assign masterIrq        = mstat_reg[4];
    assign suspendXfer      = chkSeen; // RQ18

    // ************************************************************
    // Wishbone read and acknowledge.
    // ************************************************************
    wire logic [7:0] rdMux = hitCfg5  ? cfg5View :
                             hitCfg6  ? cfg6_reg :
                             hitCfg7  ? cfg7_reg :
                             hitCtrl  ? ctrl_reg :
                             hitMstat ? {3'h0, mstat_reg} :
                             hitSstat ? {6'h00, sstat_reg} : 8'h00;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= busReq;
            wb_dat_o <= {24'h000000, rdMux};
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    property p_width;
        @(posedge clk_sys) disable iff (rst)
        $rose(pulseOn) |-> pulseOn [*5];
    endproperty
    a_width: assert property (p_width) else $error("Check pulse too short."); // RQ7

    property p_start;
        @(posedge clk_sys) disable iff (rst)
        (state_reg == cce_pkg::CCE_IDLE && syncTrig && !extended) |=> pulseOn;
    endproperty
    a_start: assert property (p_start) else $error("Check pulse started late."); // RQ7

    property p_src;
        @(posedge clk_sys) disable iff (rst)
        (setSrc && CHK_SUPPORTED) |=> !cfg5View[7];
    endproperty
    a_src: assert property (p_src) else $error("Source bit not cleared."); // RQ1

    property p_clr;
        @(posedge clk_sys) disable iff (rst)
        (clrSrc && !setSrc && !asyncTrig) |=> (cfg5_reg[7] && !async_reg);
    endproperty
    a_clr: assert property (p_clr) else $error("Clear write ignored."); // RQ3

    property p_async;
        @(posedge clk_sys) disable iff (rst)
        (async_reg && !clrSrc) |=> channel_check_line_n_oe;
    endproperty
    a_async: assert property (p_async) else $error("Latched check dropped."); // RQ13

    property p_unsup;
        @(posedge clk_sys) disable iff (rst)
        !CHK_SUPPORTED |-> cfg5View[7] && !channel_check_line_n_oe;
    endproperty
    a_unsup: assert property (p_unsup) else $error("Unsupported check visible."); // RQ4

    property p_irq;
        @(posedge clk_sys) disable iff (rst)
        chkSeen |=> masterIrq && mstat_reg[1];
    endproperty
    a_irq: assert property (p_irq) else $error("Check not posted."); // RQ18

    property p_tc;
        @(posedge clk_sys) disable iff (rst)
        (tcPend_reg && dmaSlaveSelected) |-> !terminal_count_n;
    endproperty
    a_tc: assert property (p_tc) else $error("Terminal count missing."); // RQ19

    property p_gate;
        @(posedge clk_sys) disable iff (rst)
        (state_reg == cce_pkg::CCE_HOLD && gateOff) |=> !pulseOn;
    endproperty
    a_gate: assert property (p_gate) else $error("Check not released."); // RQ12
endmodule : cce_check_unit

//--- bench/cce_far_side.sv
`timescale 1ns/1ps
module cce_far_side (
    // Clock and bench controls.
    input  wire logic                clk_sys,
    input  wire logic                rst,
    input  wire logic                start,
    input  wire logic                asyncReq,
    input  wire logic                extraCheck,
    input  wire logic [3:0]          errSel,
    input  wire logic [7:0]          causeIn,
    input  wire logic [3:0]          cmdLen,
    input  wire logic [3:0]          readyDelay,
    // Check driver of the block.
    input  wire logic                checkOe,
    input  wire logic                checkO,
    // Channel seen by the block.
    output cce_pkg::cce_chan_s       chan,
    output cce_pkg::cce_event_s      evt,
    output logic                     channel_check_n,
    output logic                     select_feedback_return_n
);
    logic [3:0] cmdCnt;
    logic [3:0] rdyCnt;
    logic       first;
    logic       ext;
    wire        cmd = cmdCnt != 4'h0;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cmdCnt <= 4'h0;
            rdyCnt <= 4'h0;
            first  <= 1'b0;
            ext    <= 1'b0;
        end
        else if (start)
        begin
            cmdCnt <= cmdLen;
            rdyCnt <= readyDelay;
            first  <= 1'b1;
            ext    <= readyDelay != 4'h0;
        end
        else
        begin
            // The command is held while the slave stretches the cycle.
            if (cmd && rdyCnt == 4'h0) cmdCnt <= cmdCnt - 4'h1;
            if (rdyCnt != 4'h0) rdyCnt <= rdyCnt - 4'h1;
            first <= 1'b0;
        end
    end
    // Parity enable follows the command of the cycle.
    assign chan = '{cmd, cmd, rdyCnt == 4'h0, 1'b0, 1'b0, 1'b0, ext};
    assign evt = '{first & errSel[3], first & errSel[0], first & errSel[1],
                   first & errSel[2], asyncReq, causeIn};
    // The check line has a pull-up; any driver pulls it low.
    assign channel_check_n = !((checkOe && !checkO) || extraCheck);
    assign select_feedback_return_n = !cmd;
endmodule : cce_far_side

//--- bench/testbench.sv
`timescale 1ns/1ps
`include "cce_map.svh"
module testbench;
    logic clk_sys = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] datI = 32'h0, datO;
    logic ack, oe, lineO, rdyO, chkN, fbN, tcN, irq, susp;
    logic start = 1'b0, asyncReq = 1'b0, extraCheck = 1'b0, owns = 1'b0, xEnd = 1'b0;
    logic rdPar = 1'b0, dmaSel = 1'b0;
    logic [3:0] errSel = 4'h0, cmdLen = 4'h0, readyDelay = 4'h0;
    logic [7:0] cause = 8'h00, q;
    cce_pkg::cce_chan_s chan;
    cce_pkg::cce_event_s evt;
    int fails = 0, check_count = 0, cycles = 0, rise, width, k;
    logic readyLow, tcSeen;
    always #5 clk_sys = ~clk_sys;
    cce_check_unit i_cce_check_unit (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(datI),
        .wb_dat_o(datO), .wb_ack_o(ack), .chan(chan), .evt(evt),
        .channel_check_line_n_o(lineO), .channel_check_line_n_oe(oe),
        .card_channel_ready_o(rdyO), .channel_check_n(chkN),
        .select_feedback_return_n(fbN), .masterOwns(owns), .masterXferEnd(xEnd),
        .readParityErr(rdPar), .dmaSlaveSelected(dmaSel), .terminal_count_n(tcN),
        .masterIrq(irq), .suspendXfer(susp));
    cce_far_side i_cce_far_side (.clk_sys(clk_sys), .rst(rst), .start(start),
        .asyncReq(asyncReq), .extraCheck(extraCheck), .errSel(errSel), .causeIn(cause),
        .cmdLen(cmdLen), .readyDelay(readyDelay), .checkOe(oe), .checkO(lineO),
        .chan(chan), .evt(evt), .channel_check_n(chkN), .select_feedback_return_n(fbN));
    // ************************************************************
    // Tasks.
    // ************************************************************
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d.", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; datI <= {24'h0, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = datO[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask : wb
    task run_cycle(input logic [3:0] es, input logic [3:0] len, input logic [3:0] rdy);
        @(posedge clk_sys);
        start <= 1'b1; errSel <= es; cmdLen <= len; readyDelay <= rdy;
        @(posedge clk_sys);
        start <= 1'b0;
        rise = -1; width = 0; readyLow = 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk_sys);
            if (rdyO === 1'b0) readyLow = 1'b1;
            if (oe === 1'b1)
            begin
                if (rise < 0) rise = i;
                width++;
            end
        end
    endtask : run_cycle
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            give_verdict();
        end
    end
    // ************************************************************
    // Scenarios.
    // ************************************************************
    initial
    begin
        void'($urandom(99707));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, `CCE_OFF_CFG5, 8'h00); chk(q, 8'hFF);
        wb(1'b0, 8'h3C, 8'h00); chk(q, 8'h00);
        wb(1'b1, `CCE_OFF_CTRL, 8'h01);
        run_cycle(4'h1, 4'h6, 4'h0); chk(32'(rise >= 0 && rise <= 5), 1);
        wb(1'b0, `CCE_OFF_CFG5, 8'h00); chk(q[7], 1'b1);
        for (k = 0; k < 4; k++)
        begin
            cause <= 8'($urandom);
            run_cycle(4'h2 << ($urandom % 3), 4'(6 + $urandom % 5), (k == 3) ? 4'h6 : 4'h0);
            chk(32'(rise >= readyDelay && rise <= readyDelay + 5), 1);
            chk(32'(width >= 5 && width <= cmdLen + readyDelay + 5), 1);
            chk(readyLow, readyDelay != 4'h0);
            wb(1'b0, `CCE_OFF_CFG5, 8'h00); chk(q[7:6], 2'b00);
            wb(1'b0, `CCE_OFF_CFG6, 8'h00); chk(q, cause);
            wb(1'b1, `CCE_OFF_CFG5, 8'hFF);
            wb(1'b0, `CCE_OFF_CFG5, 8'h00); chk(q[7], 1'b1);
        end
        @(posedge clk_sys) asyncReq <= 1'b1;
        @(posedge clk_sys) asyncReq <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk(oe, 1'b1);
        wb(1'b0, `CCE_OFF_CFG5, 8'h00); chk(q[7], 1'b0);
        wb(1'b1, `CCE_OFF_CFG5, 8'hFF);
        repeat (2) @(posedge clk_sys);
        chk(oe, 1'b0);
        owns <= 1'b1; dmaSel <= 1'b1; extraCheck <= 1'b1; rdPar <= 1'b1; tcSeen = 1'b0;
        repeat (10)
        begin
            @(posedge clk_sys);
            rdPar <= 1'b0;
            if (tcN === 1'b0) tcSeen = 1'b1;
        end
        chk(tcSeen, 1'b1);
        chk(irq, 1'b1);
        chk(susp, 1'b1);
        extraCheck <= 1'b0; owns <= 1'b0;
        wb(1'b0, `CCE_OFF_MSTAT, 8'h00); chk(q[1:0], 2'b11);
        wb(1'b1, `CCE_OFF_MSTAT, 8'hFF);
        wb(1'b0, `CCE_OFF_MSTAT, 8'h00); chk(q[1], 1'b0);
        // Status collection mode: the check line is ignored.
        wb(1'b1, `CCE_OFF_CTRL, 8'h05);
        owns <= 1'b1; extraCheck <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(susp, 1'b0);
        owns <= 1'b0; extraCheck <= 1'b0;
        wb(1'b0, `CCE_OFF_MSTAT, 8'h00); chk(q[1], 1'b0);
        give_verdict();
    end
endmodule : testbench
